// ===== ftoc_pkg.sv
package ftoc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_FAULT_MASK  = 8'h00;
	localparam logic [7:0] OFS_POLARITY    = 8'h04;
	localparam logic [7:0] OFS_FUNC_SEL    = 8'h08;
	localparam logic [7:0] OFS_TRIP_ON_DLY = 8'h0C;
	localparam logic [7:0] OFS_TRIP_OFF_DLY= 8'h10;
	localparam logic [7:0] OFS_DO_ON_DLY   = 8'h14;
	localparam logic [7:0] OFS_DO_OFF_DLY  = 8'h18;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h20;
	localparam logic [7:0] OFS_OUT_STATE   = 8'h24;
	// Fault report mask bit positions
	localparam int FM_LOW_VOLT  = 0;
	localparam int FM_OTHER     = 1;
	localparam int FM_RESTART   = 2;
	// Reset values
	localparam logic [2:0]  RST_FAULT_MASK = 3'h2;
	localparam logic [5:0]  RST_POLARITY   = 6'h00;
	localparam logic [15:0] RST_DELAY      = 16'h0000;
	// Output function code that selects the trip function
	localparam logic [4:0]  FUNC_TRIP      = 5'h1C;
	localparam int          FUNC_W         = 5;
	// Delay tick: 10 ms at 100 MHz
	localparam int CLK_HZ      = 100_000_000;
	localparam int TICK_MS     = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	// Interrupt status bits
	localparam int IRQ_TRIP_SET = 0;
	localparam int IRQ_TRIP_CLR = 1;
	localparam int IRQ_W        = 2;

	typedef struct packed {
		logic low_volt;
		logic other;
		logic restart_fail;
	} ftoc_fault_t;
endpackage

// ===== ftoc_top.sv
// How it works
// R01: Mask bit 0 routes low-voltage trips onto the fault condition.
// R02: Mask bit 1 routes every other trip onto the fault condition.
// R03: Mask bit 2 routes failed auto-restart onto the fault condition.
// R04: Outputs whose function code equals trip follow the fault condition.
// R05: Trip-mode outputs turn on after the fault assert delay.
// R06: Trip-mode outputs turn off after the fault release delay.
// R07: Ordinary outputs turn on after the output assert delay.
// R08: Ordinary outputs turn off after the output release delay.
// R09: Ordinary delays for non-trip outputs; trip outputs use fault delays.
// R10: Polarity 0 normally open, 1 normally closed.
// R11: Polarity bit 0 is first relay and transistor output upward.
// R12: Three further polarity bits cover the expansion outputs.
// R13: Expansion outputs may also carry the trip function.
// R14: Delays count 10 ms ticks; reverting source restarts the timer.
// R15: Polarity inversion comes after the delay stage.
`timescale 1ns/1ps
`default_nettype none
module ftoc_top #(
	parameter int N_OUT      = 6,
	parameter int TICK_COUNT = ftoc_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                 CLK,
	input  wire logic                 RSTN,
	// APB slave
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [7:0]           PADDR,
	input  wire logic [31:0]          PWDATA,
	output logic      [31:0]          PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR,
	// Drive status inputs, asynchronous
	input  wire logic                 FAULT_LOW_VOLT,
	input  wire logic                 FAULT_OTHER,
	input  wire logic                 RESTART_FAILED,
	input  wire logic [N_OUT-1:0]     FUNC_ACTIVE,
	input  wire logic                 EXPANSION_PRESENT,
	// Physical contacts
	output logic      [N_OUT-1:0]     CONTACT_DRIVE,
	// Interrupt
	output logic                      IRQ
);
	initial begin
		if (N_OUT < 3 || N_OUT > 6)
			$error("N_OUT must be 3 to 6");
		if (TICK_COUNT < 1)
			$error("TICK_COUNT must be at least 1");
		// The function select word must fit one bus word
		if (N_OUT * ftoc_pkg::FUNC_W > 32)
			$error("Function select field wider than the bus");
	end

	localparam int NB = 3;
	localparam int TW = $clog2(TICK_COUNT + 1);

	// Registers
	logic [2:0]                 fault_mask_ff;
	logic [N_OUT-1:0]           polarity_ff;
	logic [N_OUT*ftoc_pkg::FUNC_W-1:0] func_sel_ff;
	logic [15:0]                trip_on_ff;
	logic [15:0]                trip_off_ff;
	logic [15:0]                do_on_ff;
	logic [15:0]                do_off_ff;
	logic [ftoc_pkg::IRQ_W-1:0] irq_stat_ff;
	logic [ftoc_pkg::IRQ_W-1:0] irq_mask_ff;
	logic [ftoc_pkg::IRQ_W-1:0] nxt_irq_stat;

	// Synchronisers
	logic [N_OUT+3:0]           sync1_ff;
	logic [N_OUT+3:0]           sync2_ff;
	ftoc_pkg::ftoc_fault_t      flt;
	logic [N_OUT-1:0]           func_s;
	logic                       exp_s;

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {EXPANSION_PRESENT, FUNC_ACTIVE, RESTART_FAILED, FAULT_OTHER,
				FAULT_LOW_VOLT};
			sync2_ff <= sync1_ff;
		end
	end
	assign flt.low_volt     = sync2_ff[0];
	assign flt.other        = sync2_ff[1];
	assign flt.restart_fail = sync2_ff[2];
	assign func_s           = sync2_ff[N_OUT+2:3];
	assign exp_s            = sync2_ff[N_OUT+3];

	// Trip condition selection
	logic trip_cond;
	assign trip_cond = (fault_mask_ff[ftoc_pkg::FM_LOW_VOLT] & flt.low_volt)  // R01
		| (fault_mask_ff[ftoc_pkg::FM_OTHER] & flt.other)                      // R02
		| (fault_mask_ff[ftoc_pkg::FM_RESTART] & flt.restart_fail);            // R03

	// 10 ms tick enable
	logic [TW-1:0] tick_cnt_ff;
	logic          tick;
	assign tick = (tick_cnt_ff == TW'(TICK_COUNT - 1));
	always_ff @(posedge CLK) begin
		if (!RSTN)
			tick_cnt_ff <= '0;
		else if (tick)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= tick_cnt_ff + 1'b1; // R14
	end

	// Per-output delay stage
	logic [N_OUT-1:0] state_ff;
	logic [15:0]      dly_cnt_ff [N_OUT];
	logic [N_OUT-1:0] is_trip;
	logic [N_OUT-1:0] src;
	logic [N_OUT-1:0] present;

	always_comb begin
		for (int i = 0; i < N_OUT; i++) begin
			present[i] = (i < NB) || exp_s; // R12
			is_trip[i] = func_sel_ff[i*ftoc_pkg::FUNC_W +: ftoc_pkg::FUNC_W]
				== ftoc_pkg::FUNC_TRIP; // R04 R13
			src[i] = present[i] & (is_trip[i] ? trip_cond : func_s[i]); // R04
		end
	end

	// Delay target per output, picked by mode and direction
	logic [15:0]      dly_tgt [N_OUT];
	logic [N_OUT-1:0] expired;
	always_comb begin
		for (int i = 0; i < N_OUT; i++) begin
			if (is_trip[i])
				dly_tgt[i] = src[i] ? trip_on_ff : trip_off_ff; // R05 R06
			else
				dly_tgt[i] = src[i] ? do_on_ff : do_off_ff; // R07 R08 R09
			expired[i] = (src[i] != state_ff[i]) && (dly_cnt_ff[i] >= dly_tgt[i]);
		end
	end

	// Logical state moves only once its delay has run out
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			state_ff <= '0;
		end else begin
			for (int i = 0; i < N_OUT; i++) begin
				if (expired[i])
					state_ff[i] <= src[i]; // R05 R06 R07 R08 R09
			end
		end
	end

	// A reverting source clears the count, so the timer restarts
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			for (int i = 0; i < N_OUT; i++)
				dly_cnt_ff[i] <= '0;
		end else begin
			for (int i = 0; i < N_OUT; i++) begin
				if (src[i] == state_ff[i] || expired[i])
					dly_cnt_ff[i] <= '0; // R14
				else if (tick)
					dly_cnt_ff[i] <= dly_cnt_ff[i] + 16'h0001; // R14
			end
		end
	end

	// Polarity after delay; bit 0 is the first output
	always_ff @(posedge CLK) begin
		if (!RSTN)
			CONTACT_DRIVE <= '0;
		else
			CONTACT_DRIVE <= (state_ff ^ polarity_ff) & present; // R10 R11 R15
	end

	// Trip output edge events
	logic any_trip_prev_ff;
	logic any_trip;
	logic trip_rise;
	logic trip_fall;
	assign any_trip = |(state_ff & is_trip);
	assign trip_rise = any_trip & ~any_trip_prev_ff;
	assign trip_fall = ~any_trip & any_trip_prev_ff;
	always_ff @(posedge CLK) begin
		if (!RSTN)
			any_trip_prev_ff <= 1'b0;
		else
			any_trip_prev_ff <= any_trip;
	end

	// APB
	logic wr;
	logic rd_ok;
	assign wr      = PSEL & PENABLE & PWRITE;
	assign PREADY  = 1'b1;
	always_comb begin
		rd_ok = 1'b1;
		case (PADDR)
			ftoc_pkg::OFS_FAULT_MASK, ftoc_pkg::OFS_POLARITY, ftoc_pkg::OFS_FUNC_SEL,
			ftoc_pkg::OFS_TRIP_ON_DLY, ftoc_pkg::OFS_TRIP_OFF_DLY, ftoc_pkg::OFS_DO_ON_DLY,
			ftoc_pkg::OFS_DO_OFF_DLY, ftoc_pkg::OFS_IRQ_STATUS, ftoc_pkg::OFS_IRQ_MASK,
			ftoc_pkg::OFS_OUT_STATE: rd_ok = 1'b1;
			default: rd_ok = 1'b0;
		endcase
	end
	assign PSLVERR = PSEL & PENABLE & ~rd_ok;

	// One block per register; unmapped and read-only writes fall through
	always_ff @(posedge CLK) begin
		if (!RSTN)
			fault_mask_ff <= ftoc_pkg::RST_FAULT_MASK;
		else if (wr && PADDR == ftoc_pkg::OFS_FAULT_MASK)
			fault_mask_ff <= PWDATA[2:0];
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			polarity_ff <= N_OUT'(ftoc_pkg::RST_POLARITY);
		else if (wr && PADDR == ftoc_pkg::OFS_POLARITY)
			polarity_ff <= PWDATA[N_OUT-1:0];
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			func_sel_ff <= '0;
		else if (wr && PADDR == ftoc_pkg::OFS_FUNC_SEL)
			func_sel_ff <= PWDATA[N_OUT*ftoc_pkg::FUNC_W-1:0];
	end

	// A delay change applies at once, even to a running count
	always_ff @(posedge CLK) begin
		if (!RSTN)
			trip_on_ff <= ftoc_pkg::RST_DELAY;
		else if (wr && PADDR == ftoc_pkg::OFS_TRIP_ON_DLY)
			trip_on_ff <= PWDATA[15:0];
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			trip_off_ff <= ftoc_pkg::RST_DELAY;
		else if (wr && PADDR == ftoc_pkg::OFS_TRIP_OFF_DLY)
			trip_off_ff <= PWDATA[15:0];
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			do_on_ff <= ftoc_pkg::RST_DELAY;
		else if (wr && PADDR == ftoc_pkg::OFS_DO_ON_DLY)
			do_on_ff <= PWDATA[15:0];
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			do_off_ff <= ftoc_pkg::RST_DELAY;
		else if (wr && PADDR == ftoc_pkg::OFS_DO_OFF_DLY)
			do_off_ff <= PWDATA[15:0];
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			irq_mask_ff <= '0;
		else if (wr && PADDR == ftoc_pkg::OFS_IRQ_MASK)
			irq_mask_ff <= PWDATA[ftoc_pkg::IRQ_W-1:0];
	end

	// Sticky events; a new event wins over a write-one clear
	always_comb begin
		nxt_irq_stat = irq_stat_ff;
		if (wr && PADDR == ftoc_pkg::OFS_IRQ_STATUS)
			nxt_irq_stat = nxt_irq_stat & ~PWDATA[ftoc_pkg::IRQ_W-1:0];
		if (trip_rise)
			nxt_irq_stat[ftoc_pkg::IRQ_TRIP_SET] = 1'b1;
		if (trip_fall)
			nxt_irq_stat[ftoc_pkg::IRQ_TRIP_CLR] = 1'b1;
	end
	always_ff @(posedge CLK) begin
		if (!RSTN)
			irq_stat_ff <= '0;
		else
			irq_stat_ff <= nxt_irq_stat;
	end
	assign IRQ = |(irq_stat_ff & irq_mask_ff);

	always_comb begin
		PRDATA = 32'h0000_0000;
		case (PADDR)
			ftoc_pkg::OFS_FAULT_MASK:   PRDATA[2:0] = fault_mask_ff;
			ftoc_pkg::OFS_POLARITY:     PRDATA[N_OUT-1:0] = polarity_ff;
			ftoc_pkg::OFS_FUNC_SEL:     PRDATA[N_OUT*ftoc_pkg::FUNC_W-1:0] = func_sel_ff;
			ftoc_pkg::OFS_TRIP_ON_DLY:  PRDATA[15:0] = trip_on_ff;
			ftoc_pkg::OFS_TRIP_OFF_DLY: PRDATA[15:0] = trip_off_ff;
			ftoc_pkg::OFS_DO_ON_DLY:    PRDATA[15:0] = do_on_ff;
			ftoc_pkg::OFS_DO_OFF_DLY:   PRDATA[15:0] = do_off_ff;
			ftoc_pkg::OFS_IRQ_STATUS:   PRDATA[ftoc_pkg::IRQ_W-1:0] = irq_stat_ff;
			ftoc_pkg::OFS_IRQ_MASK:     PRDATA[ftoc_pkg::IRQ_W-1:0] = irq_mask_ff;
			ftoc_pkg::OFS_OUT_STATE:    PRDATA[N_OUT-1:0] = state_ff;
			default:                    PRDATA = 32'h0000_0000;
		endcase
	end
endmodule // ftoc_top
`default_nettype wire

// ===== ftoc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ftoc_assertions #(
	parameter int N_OUT = 6
) (
	// Clock, reset, bus
	input wire logic             CLK,
	input wire logic             RSTN,
	input wire logic             PSEL,
	input wire logic             PENABLE,
	input wire logic             PWRITE,
	input wire logic [7:0]       PADDR,
	input wire logic [31:0]      PRDATA,
	input wire logic             PREADY,
	input wire logic             PSLVERR,
	// Contacts
	input wire logic             EXPANSION_PRESENT,
	input wire logic [N_OUT-1:0] CONTACT_DRIVE,
	input wire logic             IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	wire logic acc = PSEL && PENABLE;
	wire logic bad = acc && PADDR > 8'h24;
	property p_ready; PSEL |-> PREADY; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_err; bad |-> PSLVERR; endproperty
	a_err: assert property (p_err) else $error("no error on unmapped");
	property p_ok; acc && !bad && PADDR[1:0] == 2'h0 |-> !PSLVERR; endproperty
	a_ok: assert property (p_ok) else $error("error on mapped");
	property p_bad_rd; bad && !PWRITE |-> PRDATA == 32'h0000_0000; endproperty
	a_bad_rd: assert property (p_bad_rd) else $error("unmapped read nonzero");
	property p_msk_rd; acc && PADDR == ftoc_pkg::OFS_FAULT_MASK |-> PRDATA[31:3] == '0;
	endproperty
	a_msk_rd: assert property (p_msk_rd) else $error("mask high bits set");
	property p_pol_rd; acc && PADDR == ftoc_pkg::OFS_POLARITY |-> PRDATA[31:6] == '0;
	endproperty
	a_pol_rd: assert property (p_pol_rd) else $error("polarity high bits set");
	// Reset must clear contacts even while held, so no disable here
	property p_rst; disable iff (1'b0) !RSTN |=> CONTACT_DRIVE == '0 && !IRQ; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_exp; !EXPANSION_PRESENT [*5] |-> CONTACT_DRIVE[N_OUT-1:3] == '0; endproperty
	a_exp: assert property (p_exp) else $error("absent expansion driven");
endmodule // ftoc_assertions
bind ftoc_top ftoc_assertions #(.N_OUT(N_OUT)) i_chk (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .EXPANSION_PRESENT(EXPANSION_PRESENT),
	.CONTACT_DRIVE(CONTACT_DRIVE), .IRQ(IRQ));
`default_nettype wire

// ===== ftoc_load.sv
`timescale 1ns/1ps
`default_nettype none
module ftoc_load #(
	parameter int N = 6
) (
	// Contacts in, sensed state out
	input  wire logic         clk,
	input  wire logic [N-1:0] contact,
	output logic      [N-1:0] sensed
);
	// Equipment sees a contact one cycle late, like a slow coil
	always_ff @(posedge clk) begin
		sensed <= contact;
	end
endmodule // ftoc_load
`default_nettype wire

// ===== fault_and_output_terminal_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fault_and_output_terminal_control_tb;
	logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, exp_on = 1;
	logic [7:0]  pa = 0;
	logic [31:0] pwd = 0, prd, rd;
	logic        prdy, perr, irq, ia, e;
	logic [2:0]  flt = 0;
	logic [5:0]  fa = 0, cd, out, pol;
	int          n_fail = 0, checked = 0, cyc = 0, seed = 32'hf1a6_64b1;
	ftoc_top #(.TICK_COUNT(4)) i_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
		.FAULT_LOW_VOLT(flt[0]), .FAULT_OTHER(flt[1]), .RESTART_FAILED(flt[2]),
		.FUNC_ACTIVE(fa), .EXPANSION_PRESENT(exp_on), .CONTACT_DRIVE(cd), .IRQ(irq));
	ftoc_load #(.N(6)) i_load (.clk(clk), .contact(cd), .sensed(out));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic final_report();
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Setup starts one edge after the last release, never in its time step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		rd = prd;
		e = perr;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 32'h0000_0000);
		chk(rd, x);
	endtask
	task automatic co(input logic [5:0] x);
		chk({26'h0, out}, {26'h0, x});
	endtask
	task automatic dly(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
		input logic [15:0] d);
		apb(1, ftoc_pkg::OFS_TRIP_ON_DLY, {16'h0, a});
		apb(1, ftoc_pkg::OFS_TRIP_OFF_DLY, {16'h0, b});
		apb(1, ftoc_pkg::OFS_DO_ON_DLY, {16'h0, c});
		apb(1, ftoc_pkg::OFS_DO_OFF_DLY, {16'h0, d});
	endtask
	function automatic logic [5:0] exp_cd(input logic [5:0] f, input logic t,
		input logic [5:0] p, input logic x);
		logic [5:0] s;
		s = f;
		s[3] = t;
		s = s ^ p;
		if (!x) s[5:3] = 3'h0;
		return s;
	endfunction
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1;
		rdc(ftoc_pkg::OFS_FAULT_MASK, 32'h0000_0002);
		rdc(ftoc_pkg::OFS_POLARITY, 32'h0000_0000);
		rdc(8'h40, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		apb(1, ftoc_pkg::OFS_FUNC_SEL, 32'h0000_001C);
		for (int i = 0; i < 3; i++) begin
			apb(1, ftoc_pkg::OFS_FAULT_MASK, 32'h0000_0001 << i);
			for (int j = 0; j < 3; j++) begin
				flt <= 3'h1 << j;
				tk(8);
				co({5'h0, i == j});
				flt <= 3'h0;
				tk(8);
			end
		end
		apb(1, ftoc_pkg::OFS_FAULT_MASK, 32'h0000_0002);
		dly(3, 2, 0, 0);
		flt <= 3'h2;
		tk(6);
		co(6'h00);
		tk(20);
		co(6'h01);
		flt <= 3'h0;
		tk(4);
		co(6'h01);
		tk(16);
		co(6'h00);
		dly(0, 0, 3, 3);
		flt <= 3'h2;
		fa <= 6'h02;
		tk(6);
		co(6'h01);
		tk(20);
		co(6'h03);
		flt <= 3'h0;
		fa <= 6'h00;
		tk(6);
		co(6'h02);
		tk(14);
		co(6'h00);
		fa <= 6'h02;
		tk(4);
		fa <= 6'h00;
		tk(20);
		co(6'h00);
		rdc(ftoc_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
		apb(1, ftoc_pkg::OFS_IRQ_MASK, 32'h0000_0003);
		tk(1);
		ia = irq;
		apb(1, ftoc_pkg::OFS_IRQ_MASK, 32'h0000_0000);
		tk(1);
		chk({31'h0, ia ^ irq}, 32'h0000_0001);
		apb(1, ftoc_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
		tk(1);
		chk({31'h0, irq}, 32'h0000_0000);
		rdc(ftoc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
		// Expansion output 3 carries the trip, the rest are ordinary
		apb(1, ftoc_pkg::OFS_FUNC_SEL, 32'h000E_0000);
		dly(0, 0, 0, 0);
		repeat (24) begin
			pol = 6'($random(seed));
			apb(1, ftoc_pkg::OFS_POLARITY, {26'h0, pol});
			fa <= 6'($random(seed));
			flt <= 3'($random(seed));
			exp_on <= 1'($random(seed));
			tk(10);
			co(exp_cd(fa, flt[1], pol, exp_on));
		end
		final_report();
	end
endmodule // fault_and_output_terminal_control_tb
`default_nettype wire
